// ### wsc_chk_asserts.sv
// Port-level property checker for the stream-write handler
`timescale 1ns/100ps
module wsc_chk (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    // Media and status
    input wire media_word_valid,
    input wire [15:0] media_word,
    input wire media_flush_req,
    input wire media_flush_done,
    input wire intrq,
    input wire data_request,
    input wire dma_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ****
    // Command steps
    // ****
    sequence s_pio_cmd;
        reg_wr && reg_addr == 4'h7 && reg_wdata[7:0] == 8'h3B && !data_request && !dma_mode;
    endsequence
    sequence s_drq_up;
        !data_request ##1 data_request;
    endsequence
    sequence s_pio_word;
        reg_wr && reg_addr == 4'hB && data_request;
    endsequence
    property p_pio_drq;
        s_pio_cmd |=> s_drq_up;
    endproperty
    a_pio_drq: assert property (p_pio_drq) else $error("no data request after write command");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_word_src;
        media_word_valid && !dma_mode |-> $past(reg_wr && reg_addr == 4'hB && data_request);
    endproperty
    a_word_src: assert property (p_word_src) else $error("media word without host data write");
    property p_word_val;
        s_pio_word |=> media_word_valid && media_word == $past(reg_wdata);
    endproperty
    a_word_val: assert property (p_word_val) else $error("media word differs from host data");
    property p_flush_hold;
        media_flush_req && !media_flush_done |=> media_flush_req;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("flush dropped before done");
    property p_done_flush;
        $rose(intrq) |-> !media_flush_req;
    endproperty
    a_done_flush: assert property (p_done_flush) else $error("completion while flush pending");
    property p_int_clr;
        reg_rd && reg_addr == 4'h9 |=> !intrq;
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt kept after status read");
    property p_drq_mode;
        data_request |-> !dma_mode;
    endproperty
    a_drq_mode: assert property (p_drq_mode) else $error("data request in burst mode");
    property p_end_drq;
        $rose(intrq) |-> !data_request;
    endproperty
    a_end_drq: assert property (p_end_drq) else $error("completion with data request up");
endmodule
bind wsc_stream_write wsc_chk wsc_chk_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .media_word_valid(media_word_valid), .media_word(media_word), .media_flush_req(media_flush_req),
    .media_flush_done(media_flush_done), .intrq(intrq), .data_request(data_request), .dma_mode(dma_mode));

// ### wsc_defines.vh
// Register map, field positions and timing constants of the stream-write command handler
`ifndef WSC_DEFINES_VH
`define WSC_DEFINES_VH
// ****************************************
// Register indices
// ****************************************
`define WSC_REG_FEAT_CUR 4'h0
`define WSC_REG_FEAT_PRV 4'h1
`define WSC_REG_CNT_CUR 4'h2
`define WSC_REG_CNT_PRV 4'h3
`define WSC_REG_SNUM 4'h4
`define WSC_REG_CYL_LO 4'h5
`define WSC_REG_CYL_HI 4'h6
`define WSC_REG_COMMAND 4'h7
`define WSC_REG_ERROR 4'h8
`define WSC_REG_STATUS 4'h9
`define WSC_REG_DEVCTL 4'hA
`define WSC_REG_DATA 4'hB
`define WSC_REG_CFG_STREAM 4'hC
`define WSC_REG_CFG_LIMIT 4'hD
`define WSC_REG_UNIT 4'hE
`define WSC_REG_ERRLOG 4'hF
// ****************************************
// Opcodes and field positions
// ****************************************
`define WSC_OP_STREAM_DMA 8'h3A
`define WSC_OP_STREAM_PIO 8'h3B
`define WSC_F_URGENT 7
`define WSC_F_CONT 6
`define WSC_F_FLUSH 5
`define WSC_F_RESUME 4
`define WSC_E_CRC 7
`define WSC_E_ADDRESS_NOT_FOUND_ERROR 4
`define WSC_E_ABORTED_COMMAND_ERROR 2
`define WSC_E_TIMEOUT 0
`define WSC_S_BSY 7
`define WSC_S_RDY 6
`define WSC_S_SE 5
`define WSC_S_DRQ 3
`define WSC_S_ERR 0
`define WSC_DEVCTL_HOB 7
`define WSC_L_TIMEOUT 3
// ****************************************
// Reset values and timing
// ****************************************
`define WSC_UNIT_RESET 16'h0001
`define WSC_MIN_LIMIT_US 16'h000A
`define WSC_CLK_MHZ 50
`define WSC_WORDS_PER_SECTOR 8'hFF
`endif

// ### wsc_media_model.sv
// Media-side model: slow flush and injected write faults
`timescale 1ns/100ps
module wsc_media_model (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Requests and fault control
    input wire media_flush_req,
    input wire [1:0] inject,
    // Answers
    output reg media_flush_done,
    output reg media_err_address_not_found_error,
    output reg media_err_aborted_command_error,
    output wire dma_err_crc
);
    reg [3:0] wait_q;
    // Register-fed bursts carry no checksum, so no fault here
    assign dma_err_crc = 1'b0;
    // Flush is slow on purpose so early completion shows
    always @(posedge mclk) begin
        if (sys_rst || !media_flush_req) begin
            wait_q <= 4'h0;
            media_flush_done <= 1'b0;
        end else if (wait_q == 4'h9) begin
            media_flush_done <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // Fault levels follow the bench request
    always @(posedge mclk) begin
        media_err_address_not_found_error <= inject[0] && !sys_rst;
        media_err_aborted_command_error <= inject[1] && !sys_rst;
    end
endmodule

// ### wsc_stream_write.v
// Stream-write command interpreter with register port, data handshake and completion timer
`timescale 1ns/100ps
`include "wsc_defines.vh"

// Summary of operation
// - Flush flag commits stream before completion
// - Resume flag restarts at stream's error address
// - Low three feature bits select stream
// - Limit equals previous feature times unit
// - Zero previous feature uses stream default
// - Zero or unset default disables limit
// - Timer runs command write to completion
// - Short limits raised to built-in minimum
// - Sixteen-bit count, zero means 65536
// - Address bytes assemble into 48 bits
// - Error address readable via high-byte select
// - Error bit 0 flags time limit exceeded
// - Opcode 3Bh is programmed-I/O stream write
// - Continuous-write never aborts on errors
// - Continuous errors: SE set, ERR clear, logged
// - Continuous timeout stops, SE set, logged
// - Always attempt full transfer within limit
// - Urgent flag marks fastest completion
// - Opcode 3Ah is DMA stream write
// - DMA continuous logs interface checksum errors
module wsc_stream_write (
    // Clock, enable and reset
    input wire mclk,
    input wire clk_en,
    input wire sys_rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Media side
    output reg media_word_valid,
    output reg [15:0] media_word,
    output reg [47:0] media_lba,
    output reg media_flush_req,
    output reg [2:0] media_stream,
    output reg media_urgent,
    input wire media_flush_done,
    input wire media_err_address_not_found_error,
    input wire media_err_aborted_command_error,
    input wire dma_err_crc,
    // Status pins
    output reg intrq,
    output reg data_request,
    output reg dma_mode
);

// ****************************************
// States
// ****************************************
localparam ST_IDLE = 3'h0;
localparam ST_SETUP = 3'h1;
localparam ST_XFER = 3'h2;
localparam ST_FLUSH = 3'h3;
localparam ST_DONE = 3'h4;
// IDLE: waits for a legal opcode, refuses the rest
// SETUP: latches limit, count, address and stream
// XFER: moves words, watches errors and the limit
// FLUSH: holds completion until the media is clean
// DONE: one cycle to settle the ending status
// Only one command can be in flight at a time

reg [2:0] state_q;
reg [7:0] feat_cur_q, feat_prv_q;
reg [7:0] cnt_cur_q, cnt_prv_q;
reg [15:0] snum_q, cyl_lo_q, cyl_hi_q;
reg [7:0] error_q;
reg [7:0] status_q;
reg hob_q;
reg [15:0] unit_q;
reg [2:0] cfg_stream_q;
reg [3:0] errlog_q; // Bit 3 logs a continuous-mode timeout
reg [16:0] sect_left_q;
reg [7:0] word_cnt_q;
reg [47:0] lba_q;
reg [31:0] limit_cyc_q;
reg [31:0] timer_q;
reg limit_on_q;
reg any_err_q;
reg err_cap_q;
reg [47:0] first_err_q;
// Per-stream memory
reg [7:0] dflt_limit_mem [0:7];
reg [7:0] dflt_valid_q;
reg [47:0] err_lba_mem [0:7];
// Synchronised media error and flush-done inputs
reg [3:0] err_s1_q, err_s2_q;

// ****************************************
// Decoding helpers
// ****************************************
// Write strobe aimed at one register index
function reg_hit;
    input wr;
    input [3:0] addr;
    input [3:0] want;
    begin
        reg_hit = wr && (addr == want);
    end
endfunction

// Byte pick for address registers under high-byte select
function [7:0] pick_byte;
    input [15:0] pair;
    input high_order_byte_select;
    begin
        pick_byte = high_order_byte_select ? pair[15:8] : pair[7:0];
    end
endfunction

// ****************************************
// Command field decode
// ****************************************
// Limit arithmetic is combinational; it is only sampled in SETUP
// An unconfigured stream leaves the default unknown, masked by limit_use
wire [2:0] sid = feat_cur_q[2:0];
wire [16:0] req_sectors = ({cnt_prv_q, cnt_cur_q} == 16'h0000) ? 17'h10000 :
    {1'b0, cnt_prv_q, cnt_cur_q};
wire [47:0] req_lba = {cyl_hi_q[15:8], cyl_lo_q[15:8], snum_q[15:8],
    cyl_hi_q[7:0], cyl_lo_q[7:0], snum_q[7:0]};
wire [7:0] mult_sel = (feat_prv_q != 8'h00) ? feat_prv_q : dflt_limit_mem[sid];
wire limit_use = (feat_prv_q != 8'h00) ||
    (dflt_valid_q[sid] && dflt_limit_mem[sid] != 8'h00);
wire [23:0] limit_us_raw = mult_sel * unit_q;
wire [23:0] limit_us = (limit_us_raw < {8'h00, `WSC_MIN_LIMIT_US}) ?
    {8'h00, `WSC_MIN_LIMIT_US} : limit_us_raw;
wire cont = feat_cur_q[`WSC_F_CONT];
wire is_cmd = reg_hit(reg_wr, reg_addr, `WSC_REG_COMMAND);
wire valid_op = reg_wdata[7:0] == `WSC_OP_STREAM_PIO || reg_wdata[7:0] == `WSC_OP_STREAM_DMA;
wire err_ev = err_s2_q[0] | err_s2_q[1] | (dma_mode & err_s2_q[2]);
// Data writes outside a data request are dropped, not queued
wire data_wr = reg_hit(reg_wr, reg_addr, `WSC_REG_DATA) && data_request;
wire word_take = (state_q == ST_XFER) && (dma_mode ? 1'b1 : data_wr);
wire timed_out = limit_on_q && timer_q >= limit_cyc_q;

// ****************************************
// Input synchroniser
// ****************************************
always @(posedge mclk) begin
    if (sys_rst) begin
        err_s1_q <= 4'h0;
        err_s2_q <= 4'h0;
    end else if (clk_en) begin
        err_s1_q <= {media_flush_done, dma_err_crc, media_err_aborted_command_error, media_err_address_not_found_error};
        err_s2_q <= err_s1_q;
    end
end

// ****************************************
// Command engine
// ****************************************
always @(posedge mclk) begin
    if (sys_rst) begin
        state_q <= ST_IDLE;
        feat_cur_q <= 8'h00;
        feat_prv_q <= 8'h00;
        cnt_cur_q <= 8'h00;
        cnt_prv_q <= 8'h00;
        snum_q <= 16'h0000;
        cyl_lo_q <= 16'h0000;
        cyl_hi_q <= 16'h0000;
        error_q <= 8'h00;
        status_q <= 8'h40;
        hob_q <= 1'b0;
        unit_q <= `WSC_UNIT_RESET;
        cfg_stream_q <= 3'h0;
        errlog_q <= 4'h0;
        sect_left_q <= 17'h00000;
        word_cnt_q <= 8'h00;
        lba_q <= 48'h000000000000;
        limit_cyc_q <= 32'h00000000;
        timer_q <= 32'h00000000;
        limit_on_q <= 1'b0;
        any_err_q <= 1'b0;
        err_cap_q <= 1'b0;
        first_err_q <= 48'h000000000000;
        dflt_valid_q <= 8'h00;
        reg_rdata <= 16'h0000;
        media_word_valid <= 1'b0;
        media_word <= 16'h0000;
        media_lba <= 48'h000000000000;
        media_flush_req <= 1'b0;
        media_stream <= 3'h0;
        media_urgent <= 1'b0;
        intrq <= 1'b0;
        data_request <= 1'b0;
        dma_mode <= 1'b0;
    end else if (clk_en) begin
        media_word_valid <= 1'b0;
        // Register writes; taskfile ignored while busy to keep the command stable
        if (reg_wr && !status_q[`WSC_S_BSY]) begin
            case (reg_addr)
                `WSC_REG_FEAT_CUR: feat_cur_q <= reg_wdata[7:0];
                `WSC_REG_FEAT_PRV: feat_prv_q <= reg_wdata[7:0];
                `WSC_REG_CNT_CUR: cnt_cur_q <= reg_wdata[7:0];
                `WSC_REG_CNT_PRV: cnt_prv_q <= reg_wdata[7:0];
                `WSC_REG_SNUM: snum_q <= reg_wdata;
                `WSC_REG_CYL_LO: cyl_lo_q <= reg_wdata;
                `WSC_REG_CYL_HI: cyl_hi_q <= reg_wdata;
                `WSC_REG_DEVCTL: hob_q <= reg_wdata[`WSC_DEVCTL_HOB];
                `WSC_REG_CFG_STREAM: cfg_stream_q <= reg_wdata[2:0];
                `WSC_REG_CFG_LIMIT: begin
                    dflt_limit_mem[cfg_stream_q] <= reg_wdata[7:0];
                    dflt_valid_q[cfg_stream_q] <= 1'b1;
                end
                `WSC_REG_UNIT: unit_q <= reg_wdata;
                default: ;
            endcase
        end
        // Read data one cycle after the strobe; status reads also drop the interrupt
        if (reg_rd) begin
            case (reg_addr)
                `WSC_REG_SNUM: reg_rdata <= {8'h00, pick_byte(snum_q, hob_q)};
                `WSC_REG_CYL_LO: reg_rdata <= {8'h00, pick_byte(cyl_lo_q, hob_q)};
                `WSC_REG_CYL_HI: reg_rdata <= {8'h00, pick_byte(cyl_hi_q, hob_q)};
                `WSC_REG_ERROR: reg_rdata <= {8'h00, error_q};
                `WSC_REG_STATUS: reg_rdata <= {8'h00, status_q};
                `WSC_REG_UNIT: reg_rdata <= unit_q;
                `WSC_REG_ERRLOG: reg_rdata <= {12'h000, errlog_q};
                default: reg_rdata <= 16'h0000;
            endcase
            if (reg_addr == `WSC_REG_STATUS)
                intrq <= 1'b0;
        end else begin
            reg_rdata <= 16'h0000;
        end
        // Clock-cycle timer, counts from command write to completion interrupt
        if (state_q != ST_IDLE && state_q != ST_DONE) begin
            timer_q <= timer_q + 32'h00000001;
        end
        // Status and interrupt follow the state; the set of intrq comes after the
        // read-clear above, so a completion in the read cycle is never lost
        case (state_q)
            ST_IDLE: begin
                // Opcode checked on the strobe itself; the taskfile is already latched
                if (is_cmd && !status_q[`WSC_S_BSY] && valid_op) begin
                    state_q <= ST_SETUP;
                    dma_mode <= reg_wdata[7:0] == `WSC_OP_STREAM_DMA;
                    status_q <= 8'h80;
                    error_q <= 8'h00;
                    errlog_q <= 4'h0;
                    timer_q <= 32'h00000000;
                    any_err_q <= 1'b0;
                    err_cap_q <= 1'b0;
                end else if (is_cmd && !status_q[`WSC_S_BSY]) begin
                    error_q <= 8'h04;
                    status_q <= 8'h41;
                    intrq <= 1'b1;
                end
            end
            ST_SETUP: begin
                // Limit is frozen here so later feature writes cannot move it
                // Timer already runs in this cycle, as the limit counts from the strobe
                limit_cyc_q <= limit_us * `WSC_CLK_MHZ;
                limit_on_q <= limit_use;
                sect_left_q <= req_sectors;
                lba_q <= feat_cur_q[`WSC_F_RESUME] ? err_lba_mem[sid] : req_lba;
                media_stream <= sid;
                media_urgent <= feat_cur_q[`WSC_F_URGENT];
                word_cnt_q <= 8'h00;
                data_request <= !dma_mode;
                status_q <= dma_mode ? 8'h80 : 8'h48;
                state_q <= ST_XFER;
            end
            ST_XFER: begin
                // A sector is 256 words; the address steps on the last one
                // Burst mode takes a word every cycle with no pacing of its own
                if (word_take) begin
                    media_word_valid <= 1'b1;
                    media_word <= reg_wdata;
                    media_lba <= lba_q;
                    word_cnt_q <= word_cnt_q + 8'h01;
                    if (word_cnt_q == `WSC_WORDS_PER_SECTOR) begin
                        lba_q <= lba_q + 48'h000000000001;
                        sect_left_q <= sect_left_q - 17'h00001;
                    end
                end
                // Error capture; first one stored as the reported address
                if (err_ev) begin
                    any_err_q <= 1'b1;
                    if (err_s2_q[0]) errlog_q[1] <= 1'b1;
                    if (err_s2_q[1]) errlog_q[2] <= 1'b1;
                    if (dma_mode && err_s2_q[2]) errlog_q[0] <= 1'b1;
                    if (!err_cap_q) begin
                        err_cap_q <= 1'b1;
                        first_err_q <= lba_q;
                        err_lba_mem[sid] <= lba_q;
                    end
                end
                // Priority: limit expiry, then abort on error, then normal end
                if (timed_out) begin
                    state_q <= ST_DONE;
                    data_request <= 1'b0;
                    error_q[`WSC_E_TIMEOUT] <= 1'b1;
                    status_q <= cont ? 8'h60 : 8'h41;
                    intrq <= 1'b1;
                end else if (err_ev && !cont) begin
                    state_q <= ST_DONE;
                    data_request <= 1'b0;
                    error_q <= {dma_mode & err_s2_q[2], 2'b00, err_s2_q[0], 1'b0, err_s2_q[1], 2'b00};
                    status_q <= 8'h41;
                    {cyl_hi_q[15:8], cyl_lo_q[15:8], snum_q[15:8],
                        cyl_hi_q[7:0], cyl_lo_q[7:0], snum_q[7:0]} <= lba_q;
                    intrq <= 1'b1;
                end else if (word_take && word_cnt_q == `WSC_WORDS_PER_SECTOR &&
                        sect_left_q == 17'h00001) begin
                    data_request <= 1'b0;
                    media_flush_req <= feat_cur_q[`WSC_F_FLUSH];
                    status_q <= 8'h80;
                    state_q <= ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                // Completion held back until the media reports the flush done
                // The done input arrives two cycles late through the synchroniser
                // A flush that outlasts the limit is cut short and reported
                if (!media_flush_req || err_s2_q[3]) begin
                    media_flush_req <= 1'b0;
                    state_q <= ST_DONE;
                    status_q <= any_err_q ? 8'h60 : 8'h40;
                    if (any_err_q)
                        {cyl_hi_q[15:8], cyl_lo_q[15:8], snum_q[15:8],
                            cyl_hi_q[7:0], cyl_lo_q[7:0], snum_q[7:0]} <= first_err_q;
                    intrq <= 1'b1;
                end else if (timed_out) begin
                    media_flush_req <= 1'b0;
                    state_q <= ST_DONE;
                    error_q[`WSC_E_TIMEOUT] <= 1'b1;
                    status_q <= cont ? 8'h60 : 8'h41;
                    intrq <= 1'b1;
                end
            end
            ST_DONE: begin
                // Continuous timeout moves from the error register to the log
                state_q <= ST_IDLE;
                if (status_q[`WSC_S_SE] && error_q[`WSC_E_TIMEOUT]) begin
                    errlog_q[`WSC_L_TIMEOUT] <= 1'b1;
                    error_q <= 8'h00;
                end
            end
            // Unused codes fall back to idle
            default: state_q <= ST_IDLE;
        endcase
    end
end

endmodule

// ### wsc_stream_write_tb_top.sv
// Self-checking bench for the stream-write handler
`timescale 1ns/100ps
module wsc_stream_write_tb_top;
    reg mclk = 1'b0;
    reg sys_rst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [1:0] inject = 2'h0;
    reg saw_fl = 1'b0;
    reg saw_dma = 1'b0;
    reg [47:0] first_lba = 48'h0;
    reg [15:0] q;
    reg [15:0] last_word = 16'h0000;
    wire murg;
    wire [15:0] reg_rdata, mword;
    wire mwv, fl_req, fl_done, e_address_not_found_error, e_aborted_command_error, e_crc, intrq, drq, dmam;
    wire [47:0] mlba;
    wire [2:0] mstr;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int nw = 0;
    int n;
    wsc_stream_write wsc_stream_write_inst (.mclk(mclk), .clk_en(1'b1), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .media_word_valid(mwv), .media_word(mword), .media_lba(mlba), .media_flush_req(fl_req),
        .media_stream(mstr), .media_urgent(murg), .media_flush_done(fl_done), .media_err_address_not_found_error(e_address_not_found_error),
        .media_err_aborted_command_error(e_aborted_command_error), .dma_err_crc(e_crc), .intrq(intrq), .data_request(drq), .dma_mode(dmam));
    wsc_media_model wsc_media_model_inst (.mclk(mclk), .sys_rst(sys_rst), .media_flush_req(fl_req),
        .inject(inject), .media_flush_done(fl_done), .media_err_address_not_found_error(e_address_not_found_error), .media_err_aborted_command_error(e_aborted_command_error),
        .dma_err_crc(e_crc));
    always #10 mclk = ~mclk;
    // Word count, first address and hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (fl_req === 1'b1) saw_fl <= 1'b1;
        if (dmam === 1'b1) saw_dma <= 1'b1;
        if (mwv === 1'b1) begin
            if (nw == 0) first_lba <= mlba;
            last_word <= mword;
            nw <= nw + 1;
        end
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            conclude;
        end
    end
    task chk(input [47:0] got, input [47:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    // Bounded wait: 0 for data request, 1 for completion
    task await(input int sel);
        n = 0;
        while ((sel ? intrq : drq) !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1 n = n + 1;
        end
        if (n >= 3000) n_mismatch = n_mismatch + 1;
    endtask
    task cmd(input [7:0] fc, input [7:0] fp, input [47:0] lba, input [7:0] op);
        nw = 0;
        wr(4'h0, {8'h00, fc});
        wr(4'h1, {8'h00, fp});
        wr(4'h2, 16'h0001);
        wr(4'h3, 16'h0000);
        wr(4'h4, {lba[31:24], lba[7:0]});
        wr(4'h5, {lba[39:32], lba[15:8]});
        wr(4'h6, {lba[47:40], lba[23:16]});
        wr(4'h7, {8'h00, op});
    endtask
    task send;
        for (int i = 0; i < 256; i++) wr(4'hB, 16'h0100 + i[15:0]);
    endtask
    task t_reset;
        rd(4'h9);
        chk(q, 16'h0040);
        rd(4'hE);
        chk(q, 16'h0001);
        $display("reset test done");
    endtask
    task t_pio;
        cmd(8'h23, 8'h00, 48'hA1B2C3D4E5F6, 8'h3B);
        await(0);
        chk(mstr, 3'h3);
        send;
        await(1);
        chk(nw, 256);
        chk(last_word, 16'h01FF);
        chk(first_lba, 48'hA1B2C3D4E5F6);
        chk(saw_fl, 1'b1);
        rd(4'h9);
        chk(q, 16'h0040);
        chk(intrq, 1'b0);
        $display("write test done");
    endtask
    task t_bad;
        wr(4'h7, 16'h0050);
        await(1);
        rd(4'h8);
        chk(q, 16'h0004);
        rd(4'h9);
        chk(q, 16'h0041);
        $display("refused opcode test done");
    endtask
    // Limits of 10 (raised from 1), 20 and default 30 microseconds
    task t_tmo;
        int lim;
        for (int k = 0; k < 3; k++) begin
            lim = 500 * (k + 1);
            if (k == 2) wr(4'hC, 16'h0000);
            if (k == 2) wr(4'hD, 16'h001E);
            cmd(k == 1 ? 8'h80 : 8'h00, k == 0 ? 8'h01 : (k == 1 ? 8'h14 : 8'h00), 48'h0, 8'h3B);
            await(1);
            chk(n >= lim - 50 && n <= lim + 8, 1'b1);
            chk(murg, k == 1);
            rd(4'h8);
            chk(q, 16'h0001);
            rd(4'h9);
            chk(q, 16'h0041);
        end
        $display("time limit test done");
    endtask
    task t_cont;
        cmd(8'h45, 8'h00, 48'h00AB00001234, 8'h3B);
        await(0);
        @(posedge mclk);
        inject <= 2'h3;
        send;
        inject <= 2'h0;
        await(1);
        chk(nw, 256);
        rd(4'h9);
        chk(q, 16'h0060);
        rd(4'hF);
        chk(q, 16'h0006);
        rd(4'h4);
        chk(q, 16'h0034);
        wr(4'hA, 16'h0080);
        rd(4'h5);
        chk(q, 16'h00AB);
        wr(4'hA, 16'h0000);
        // Resume on the same stream restarts at the logged error address
        cmd(8'h15, 8'h00, 48'h0, 8'h3B);
        await(0);
        send;
        await(1);
        chk(first_lba, 48'h00AB00001234);
        rd(4'h9);
        chk(q, 16'h0040);
        $display("continuous test done");
    endtask
    task t_dma;
        cmd(8'h06, 8'h00, 48'h000000000200, 8'h3A);
        await(1);
        chk(saw_dma, 1'b1);
        chk(nw, 256);
        rd(4'h9);
        chk(q, 16'h0040);
        $display("burst test done");
    endtask
    task conclude;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Reset, then every scenario in turn
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset;
        t_pio;
        t_bad;
        t_tmo;
        t_cont;
        t_dma;
        conclude;
    end
endmodule
